// ### src/scio_pkg.sv
// Shared constants, codes and carrier types of the serial controlled IO port
package scio_pkg;

  // Geometry
  localparam int NLINES = 5;
  localparam int AW     = 8;
  localparam int DW     = 32;
  localparam int ADC_W  = 12;
  localparam int CNT_W  = 24;

  // Register byte offsets
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_MODE  = 8'h04;
  localparam logic [7:0] A_RTYPE = 8'h08;
  localparam logic [7:0] A_MAP   = 8'h0C;
  localparam logic [7:0] A_IVAL  = 8'h10;
  localparam logic [7:0] A_STAT  = 8'h14;
  localparam logic [2:0] A_CODE_HI = 3'h1;  // 0x20..0x3F, one word per line
  localparam logic [2:0] A_VAL_HI  = 3'h2;  // 0x40..0x5F, one word per line

  // Field positions
  localparam int CTRL_CFG = 0;
  localparam int CTRL_ACT = 1;
  localparam int CB_QRY   = 0;
  localparam int CB_HI    = 8;
  localparam int CB_LO    = 16;
  localparam int CB_RSP   = 24;

  // Values after reset
  localparam logic [15:0] IVAL_RST = 16'h1388;  // 5000 ms

  // Line capabilities: digital modes on lines 1-3, sampling on lines 4-5
  localparam logic [4:0] CAP_DIG = 5'h07;
  localparam logic [4:0] CAP_ADC = 5'h18;

  // Byte that opens the configuration state
  localparam logic [7:0] CFG_KEY = 8'h73;

  // Timing
  localparam int CLK_NS     = 50;
  localparam int MS_NS      = 1000000;
  localparam int MS_CYC_DEF = (MS_NS + CLK_NS - 1) / CLK_NS;

  // Working modes of a line
  typedef enum logic [2:0] {
    M_OFF  = 3'h0,
    M_IN   = 3'h1,
    M_OUT  = 3'h2,
    M_IND  = 3'h3,
    M_WAKE = 3'h4,
    M_ADC  = 3'h6
  } scio_mode_t;

  // Report types of an input line
  localparam logic [1:0] RT_QUERY  = 2'h0;
  localparam logic [1:0] RT_TIME   = 2'h1;
  localparam logic [1:0] RT_CHANGE = 2'h2;

  // Sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_SCAN = 3'h1,
    S_CMP  = 3'h2,
    S_TXRD = 3'h3,
    S_TXLD = 3'h4,
    S_SEND = 3'h5
  } scio_seq_t;

  // Register port request
  typedef struct packed {
    logic          wr;
    logic          rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } scio_bus_req_t;

  // Whole state of the top module
  typedef struct packed {
    scio_seq_t                     st;
    logic [2:0]                    line;
    logic                          sel_rsp;
    logic [7:0]                    rx_buf;
    logic                          rx_full;
    logic                          rx_rdy;
    logic [NLINES-1:0]             pend_rep;
    logic [NLINES-1:0]             pend_rsp;
    logic [NLINES-1:0]             lvl_prev;
    logic [CNT_W-1:0]              ms_cnt;
    logic [15:0]                   int_cnt;
    logic                          config_st;
    logic                          act_io;
    scio_mode_t [NLINES-1:0]       mode;
    logic [NLINES-1:0][1:0]        rtype;
    logic [NLINES-1:0][2:0]        map;
    logic [15:0]                   interval;
    logic [NLINES-1:0]             out_lvl;
    logic [NLINES-1:0]             io_out;
    logic [NLINES-1:0]             io_oe;
    logic [7:0]                    tx_data;
    logic                          tx_valid;
    logic [DW-1:0]                 rd_data;
    logic                          link_active;
  } scio_state_t;

endpackage

// ### src/scio_sync.sv
// Two-stage synchroniser for a group of pin levels
`timescale 1ns/10ps
module scio_sync #(
  parameter int W = 5
) (
  // Clock and reset
  input  wire logic         clock_i,
  input  wire logic         resetn_i,
  // Levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [1:0][W-1:0] stg_q;
  logic [1:0][W-1:0] stg_d;

  // First stage feeds only the second stage
  always_comb begin
    stg_d[0] = d_i;
    stg_d[1] = stg_q[0];
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      stg_q <= '0;
    end else begin
      stg_q <= stg_d;
    end
  end

  assign q_o = stg_q[1];

endmodule

// ### src/scio_mem.sv
// Small code-byte memory with one write port and a registered read port
`timescale 1ns/10ps
module scio_mem #(
  parameter int W  = 32,
  parameter int D  = 5,
  parameter int AW = 3
) (
  // Clock and reset
  input  wire logic          clock_i,
  input  wire logic          resetn_i,
  // Write port
  input  wire logic          wr_en_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire logic [W-1:0]  wr_data_i,
  // Read port, data one cycle after address
  input  wire logic [AW-1:0] rd_addr_i,
  output logic      [W-1:0]  rd_data_o
);

  logic [W-1:0] mem_q [D];
  logic [W-1:0] rd_q;

  // Array holds no reset; codes are undefined until the first write to each line
  always_ff @(posedge clock_i) begin
    if (wr_en_i && (int'(wr_addr_i) < D)) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  // Out-of-range read gives zero
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      rd_q <= '0;
    end else if (int'(rd_addr_i) < D) begin
      rd_q <= mem_q[rd_addr_i];
    end else begin
      rd_q <= '0;
    end
  end

  assign rd_data_o = rd_q;

endmodule

// ### src/scio_top.sv
// Serial controlled IO port: five lines, register port and serial byte stream
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/10ps
module scio_top #(
  parameter int MS_CYCLES = scio_pkg::MS_CYC_DEF
) (
  // Clock and reset
  input  wire logic                             clock_i,
  input  wire logic                             resetn_i,
  // Register port
  input  wire scio_pkg::scio_bus_req_t          bus_i,
  output logic      [scio_pkg::DW-1:0]          rd_data_o,
  // IO pins
  input  wire logic [scio_pkg::NLINES-1:0]      io_pin_i,
  output logic      [scio_pkg::NLINES-1:0]      io_out_o,
  output logic      [scio_pkg::NLINES-1:0]      io_oe_o,
  // Converter results for lines 4 and 5
  input  wire logic [1:0][scio_pkg::ADC_W-1:0]  adc_val_i,
  // Centre online flags
  input  wire logic [scio_pkg::NLINES-1:0]      centre_online_i,
  // Serial receive bytes
  input  wire logic [7:0]                       rx_data_i,
  input  wire logic                             rx_valid_i,
  output logic                                  rx_ready_o,
  // Serial transmit bytes
  output logic      [7:0]                       tx_data_o,
  output logic                                  tx_valid_o,
  input  wire logic                             tx_ready_i,
  // Link control and state
  output logic                                  link_active_o,
  output logic                                  config_state_o
);

  scio_pkg::scio_state_t         s_q;
  scio_pkg::scio_state_t         s_d;
  logic [scio_pkg::NLINES-1:0]   lvl;
  logic [scio_pkg::DW-1:0]       mem_q;
  logic                          mem_we;
  logic [2:0]                    bus_idx;
  logic                          tick;
  logic                          expire;
  logic [scio_pkg::NLINES-1:0]   chg_mask;
  logic [scio_pkg::NLINES-1:0]   time_mask;
  logic [scio_pkg::NLINES-1:0]   wake_mask;

  // Pins are asynchronous; only the synchronised copy is used
  scio_sync #(.W(scio_pkg::NLINES)) u_sync (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .d_i      (io_pin_i),
    .q_o      (lvl)
  );

  assign bus_idx = bus_i.addr[4:2];
  assign mem_we  = bus_i.wr && (bus_i.addr[7:5] == scio_pkg::A_CODE_HI) && (bus_idx < 3'h5);

  // Per-line code bytes: query, high, low, response
  scio_mem #(.W(scio_pkg::DW), .D(scio_pkg::NLINES), .AW(3)) u_mem (
    .clock_i   (clock_i),
    .resetn_i  (resetn_i),
    .wr_en_i   (mem_we),
    .wr_addr_i (bus_idx),
    .wr_data_i (bus_i.wdata),
    .rd_addr_i (s_q.line),
    .rd_data_o (mem_q)
  );

  // Only modes a line can carry are accepted
  function automatic logic mode_ok(input int i, input logic [2:0] m);
    logic dig;
    dig = (m == scio_pkg::M_IN) || (m == scio_pkg::M_OUT) ||
          (m == scio_pkg::M_IND) || (m == scio_pkg::M_WAKE);
    mode_ok = (m == scio_pkg::M_OFF) || (scio_pkg::CAP_DIG[i] && dig) ||
              (scio_pkg::CAP_ADC[i] && (m == scio_pkg::M_ADC));
  endfunction

  // Millisecond tick and interval expiry
  assign tick   = (s_q.ms_cnt == scio_pkg::CNT_W'(MS_CYCLES - 1));
  assign expire = tick && (s_q.interval != 16'h0) &&
                  (s_q.int_cnt == s_q.interval - 16'h1);

  // Line masks for the report sources
  always_comb begin
    for (int i = 0; i < scio_pkg::NLINES; i++) begin
      chg_mask[i]  = (s_q.mode[i] == scio_pkg::M_IN) && (s_q.rtype[i] == scio_pkg::RT_CHANGE) &&
                     (lvl[i] != s_q.lvl_prev[i]);
      time_mask[i] = (s_q.mode[i] == scio_pkg::M_IN) && (s_q.rtype[i] == scio_pkg::RT_TIME);
      wake_mask[i] = (s_q.mode[i] == scio_pkg::M_WAKE) && lvl[i];
    end
  end

  // Next state
  always_comb begin
    logic [2:0] m;
    logic [2:0] c;
    logic       hit;
    m   = 3'h0;
    c   = 3'h0;
    hit = 1'b0;
    s_d = s_q;
    s_d.rd_data  = '0;
    s_d.ms_cnt   = tick ? '0 : s_q.ms_cnt + scio_pkg::CNT_W'(1);
    if (tick) begin
      s_d.int_cnt = expire ? 16'h0 : s_q.int_cnt + 16'h1;
    end
    s_d.lvl_prev = lvl;

    // Receive byte accepted while the holding slot is free
    if (rx_valid_i && s_q.rx_rdy) begin
      s_d.rx_buf  = rx_data_i;
      s_d.rx_full = 1'b1;
    end

    // Sequencer: scan received byte, or send a pending byte
    case (s_q.st)
      scio_pkg::S_IDLE: begin
        if (s_q.rx_full) begin
          s_d.line = 3'h0;
          s_d.st   = scio_pkg::S_SCAN;
          if (s_q.rx_buf == scio_pkg::CFG_KEY) begin
            s_d.config_st = 1'b1;
          end
        end else if (|(s_q.pend_rep | s_q.pend_rsp)) begin
          for (int i = scio_pkg::NLINES - 1; i >= 0; i--) begin
            if (s_q.pend_rep[i] || s_q.pend_rsp[i]) begin
              s_d.line    = 3'(i);
              s_d.sel_rsp = s_q.pend_rsp[i];
            end
          end
          s_d.st = scio_pkg::S_TXRD;
        end
      end
      scio_pkg::S_SCAN: begin
        s_d.st = scio_pkg::S_CMP;
      end
      scio_pkg::S_CMP: begin
        if (s_q.mode[s_q.line] == scio_pkg::M_IN && s_q.rtype[s_q.line] == scio_pkg::RT_QUERY &&
            s_q.rx_buf == mem_q[scio_pkg::CB_QRY +: 8]) begin
          s_d.pend_rep[s_q.line] = 1'b1;
        end
        if (s_q.mode[s_q.line] == scio_pkg::M_OUT) begin
          if (s_q.rx_buf == mem_q[scio_pkg::CB_HI +: 8]) begin
            s_d.out_lvl[s_q.line]  = 1'b1;
            s_d.pend_rsp[s_q.line] = 1'b1;
          end else if (s_q.rx_buf == mem_q[scio_pkg::CB_LO +: 8]) begin
            s_d.out_lvl[s_q.line]  = 1'b0;
            s_d.pend_rsp[s_q.line] = 1'b1;
          end
        end
        if (s_q.line == 3'h4) begin
          s_d.rx_full = 1'b0;
          s_d.st      = scio_pkg::S_IDLE;
        end else begin
          s_d.line = s_q.line + 3'h1;
          s_d.st   = scio_pkg::S_SCAN;
        end
      end
      scio_pkg::S_TXRD: begin
        s_d.st = scio_pkg::S_TXLD;
      end
      scio_pkg::S_TXLD: begin
        // Level taken at send time, so the report shows the present state
        if (s_q.sel_rsp) begin
          s_d.tx_data = mem_q[scio_pkg::CB_RSP +: 8];
        end else if (lvl[s_q.line]) begin
          s_d.tx_data = mem_q[scio_pkg::CB_HI +: 8];
        end else begin
          s_d.tx_data = mem_q[scio_pkg::CB_LO +: 8];
        end
        s_d.tx_valid = 1'b1;
        s_d.st       = scio_pkg::S_SEND;
      end
      scio_pkg::S_SEND: begin
        if (tx_ready_i) begin
          s_d.tx_valid = 1'b0;
          s_d.st       = scio_pkg::S_IDLE;
          if (s_q.sel_rsp) begin
            s_d.pend_rsp[s_q.line] = 1'b0;
          end else begin
            s_d.pend_rep[s_q.line] = 1'b0;
          end
        end
      end
      default: begin
        s_d.st = scio_pkg::S_IDLE;
      end
    endcase

    // Event sets come after clears so a same-cycle event survives
    s_d.pend_rep = s_d.pend_rep | chg_mask;
    if (expire) begin
      s_d.pend_rep = s_d.pend_rep | time_mask;
    end

    // Register writes
    if (bus_i.wr) begin
      case (bus_i.addr)
        scio_pkg::A_CTRL: begin
          s_d.config_st = bus_i.wdata[scio_pkg::CTRL_CFG] | s_d.config_st & (s_q.st == scio_pkg::S_IDLE)
                          & s_q.rx_full & (s_q.rx_buf == scio_pkg::CFG_KEY);
          s_d.act_io    = bus_i.wdata[scio_pkg::CTRL_ACT];
        end
        scio_pkg::A_MODE: begin
          for (int i = 0; i < scio_pkg::NLINES; i++) begin
            m = bus_i.wdata[3*i +: 3];
            if (mode_ok(i, m)) begin
              s_d.mode[i] = scio_pkg::scio_mode_t'(m);
            end
          end
        end
        scio_pkg::A_RTYPE: begin
          for (int i = 0; i < scio_pkg::NLINES; i++) begin
            s_d.rtype[i] = bus_i.wdata[2*i +: 2];
          end
        end
        scio_pkg::A_MAP: begin
          for (int i = 0; i < scio_pkg::NLINES; i++) begin
            s_d.map[i] = bus_i.wdata[3*i +: 3];
          end
        end
        scio_pkg::A_IVAL: begin
          s_d.interval = bus_i.wdata[15:0];
          s_d.int_cnt  = 16'h0;
        end
        default: begin
        end
      endcase
    end

    // Register reads, data valid in the following cycle only
    if (bus_i.rd) begin
      case (bus_i.addr)
        scio_pkg::A_CTRL:  s_d.rd_data = {30'h0, s_q.act_io, s_q.config_st};
        scio_pkg::A_MODE:  s_d.rd_data = {17'h0, s_q.mode};
        scio_pkg::A_RTYPE: s_d.rd_data = {22'h0, s_q.rtype};
        scio_pkg::A_MAP:   s_d.rd_data = {17'h0, s_q.map};
        scio_pkg::A_IVAL:  s_d.rd_data = {16'h0, s_q.interval};
        scio_pkg::A_STAT:  s_d.rd_data = {20'h0, s_q.config_st, s_q.link_active, s_q.out_lvl, lvl};
        default: begin
          if (bus_i.addr[7:5] == scio_pkg::A_VAL_HI && bus_idx < 3'h5) begin
            if (s_q.mode[bus_idx] == scio_pkg::M_ADC) begin
              s_d.rd_data = {20'h0, adc_val_i[bus_idx[0] ^ 1'b1]};
            end else begin
              s_d.rd_data = {31'h0, lvl[bus_idx]};
            end
          end
        end
      endcase
    end

    // Pin drive: output level or mapped centre state
    for (int i = 0; i < scio_pkg::NLINES; i++) begin
      c = s_q.map[i] - 3'h1;
      hit = (s_q.map[i] != 3'h0) && (s_q.map[i] <= 3'h5) && centre_online_i[c];
      s_d.io_oe[i]  = (s_q.mode[i] == scio_pkg::M_OUT) || (s_q.mode[i] == scio_pkg::M_IND);
      s_d.io_out[i] = (s_q.mode[i] == scio_pkg::M_OUT) ? s_q.out_lvl[i] :
                      (s_q.mode[i] == scio_pkg::M_IND) ? hit : 1'b0;
    end

    // Activation only when IO activation is selected; low level means sleep
    s_d.link_active = s_q.act_io && (|wake_mask);
    s_d.rx_rdy      = !s_d.rx_full;
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      s_q          <= '0;
      s_q.interval <= scio_pkg::IVAL_RST;
      s_q.rx_rdy   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data_o      = s_q.rd_data;
  assign io_out_o       = s_q.io_out;
  assign io_oe_o        = s_q.io_oe;
  assign rx_ready_o     = s_q.rx_rdy;
  assign tx_data_o      = s_q.tx_data;
  assign tx_valid_o     = s_q.tx_valid;
  assign link_active_o  = s_q.link_active;
  assign config_state_o = s_q.config_st;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  sequence query_hit;
    s_q.st == scio_pkg::S_CMP && s_q.mode[s_q.line] == scio_pkg::M_IN &&
    s_q.rtype[s_q.line] == scio_pkg::RT_QUERY && s_q.rx_buf == mem_q[7:0];
  endsequence

  sequence out_hi_hit;
    s_q.st == scio_pkg::S_CMP && s_q.mode[s_q.line] == scio_pkg::M_OUT &&
    s_q.rx_buf == mem_q[15:8];
  endsequence

  sequence out_lo_hit;
    s_q.st == scio_pkg::S_CMP && s_q.mode[s_q.line] == scio_pkg::M_OUT &&
    s_q.rx_buf != mem_q[15:8] && s_q.rx_buf == mem_q[23:16];
  endsequence

  chk_query_sets_report: assert property (
    query_hit |=> s_q.pend_rep[$past(s_q.line)])
    else $error("query byte did not raise a report");

  chk_report_level_code: assert property (
    $rose(s_q.tx_valid) && !s_q.sel_rsp |->
    tx_data_o == ($past(lvl[s_q.line]) ? $past(mem_q[15:8]) : $past(mem_q[23:16])))
    else $error("report byte does not match line level");

  chk_timed_report_pend: assert property (
    expire |=> (s_q.pend_rep & $past(time_mask)) == $past(time_mask))
    else $error("timed report not raised at interval end");

  chk_change_report_pend: assert property (
    (|chg_mask) |=> (s_q.pend_rep & $past(chg_mask)) == $past(chg_mask))
    else $error("level change did not raise a report");

  chk_input_value_read: assert property (
    bus_i.rd && bus_i.addr == 8'h40 && s_q.mode[0] == scio_pkg::M_IN |=>
    rd_data_o == {31'h0, $past(lvl[0])})
    else $error("input value read wrong");

  chk_mode_caps_held: assert property (
    s_q.mode[0] != scio_pkg::M_ADC && s_q.mode[3] != scio_pkg::M_OUT)
    else $error("line holds a mode it cannot carry");

  chk_out_high_drive: assert property (
    out_hi_hit |=> s_q.out_lvl[$past(s_q.line)] && s_q.pend_rsp[$past(s_q.line)]
    ##1 io_out_o[$past(s_q.line, 2)])
    else $error("high command did not drive line high");

  chk_out_low_drive: assert property (
    out_lo_hit |=> !s_q.out_lvl[$past(s_q.line)] && s_q.pend_rsp[$past(s_q.line)])
    else $error("low command did not drive line low");

  chk_indicate_online: assert property (
    (s_q.mode[2] == scio_pkg::M_IND && s_q.map[2] == 3'h3)[*2] |->
    io_oe_o[2] && io_out_o[2] == $past(centre_online_i[2]))
    else $error("indication line does not follow centre");

  chk_wake_activate: assert property (
    (s_q.act_io && s_q.mode[0] == scio_pkg::M_WAKE && lvl[0])[*2] |-> link_active_o)
    else $error("high wake level did not activate link");

  chk_adc_value_read: assert property (
    bus_i.rd && bus_i.addr == 8'h4C && s_q.mode[3] == scio_pkg::M_ADC |=>
    rd_data_o[11:0] == $past(adc_val_i[0]))
    else $error("sample value read wrong");

  chk_config_enter: assert property (
    s_q.st == scio_pkg::S_IDLE && s_q.rx_full && s_q.rx_buf == 8'h73 && !bus_i.wr |=>
    config_state_o)
    else $error("key byte did not enter configuration state");

endmodule

// ### tb/scio_host.sv
// Serial host model: byte source toward the port and byte sink for replies
`timescale 1ns/10ps
module scio_host (
  // Clock
  input  wire logic       clock_i,
  // Bytes toward the port
  output logic      [7:0] rx_data_o,
  output logic            rx_valid_o,
  input  wire logic       rx_ready_i,
  // Bytes from the port
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o
);
  // Reply log, stall switch and error count, read by the bench
  logic [7:0] got[$];
  logic       slow       = 1'b0;
  logic [3:0] cnt        = 4'h0;
  int         err        = 0;
  initial rx_data_o      = 8'h00;
  initial rx_valid_o     = 1'b0;
  initial tx_ready_o     = 1'b1;

  // One 8N1 frame at 115200 modelled as one byte handshake
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    rx_data_o  <= b;
    rx_valid_o <= 1'b1;
    #1;
    while (!rx_ready_i && n < 200) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    if (n >= 200) err++;
    @(posedge clock_i);
    rx_valid_o <= 1'b0;
    rx_data_o  <= ~b;  // Released line must not keep the old byte
    @(posedge clock_i);
  endtask

  // Sink; slow mode stalls every other cycle like a busy host
  always @(posedge clock_i) begin
    cnt        <= cnt + 4'h1;
    tx_ready_o <= !slow || cnt[0];
    if (tx_valid_i && tx_ready_o) got.push_back(tx_data_i);
  end
endmodule

// ### tb/scio_top_tb.sv
// Self-checking bench of the serial controlled IO port
`timescale 1ns/10ps
module scio_top_tb;
  // Design connections
  logic                          clock_i;
  logic                          resetn_i;
  scio_pkg::scio_bus_req_t       bus_i;
  logic [scio_pkg::DW-1:0]       rd_data_o;
  logic [4:0]                    io_pin_i;
  logic [4:0]                    io_out_o;
  logic [4:0]                    io_oe_o;
  logic [1:0][11:0]              adc_val_i;
  logic [4:0]                    centre_online_i;
  logic [7:0]                    rx_data;
  logic                          rx_valid;
  logic                          rx_ready;
  logic [7:0]                    tx_data;
  logic                          tx_valid;
  logic                          tx_ready;
  logic                          link_active_o;
  logic                          config_state_o;
  int                            n_fail = 0;
  int                            checks = 0;

  // Short millisecond keeps timed reports within a few hundred cycles
  scio_top #(.MS_CYCLES(4)) dut (
    .clock_i(clock_i), .resetn_i(resetn_i), .bus_i(bus_i), .rd_data_o(rd_data_o),
    .io_pin_i(io_pin_i), .io_out_o(io_out_o), .io_oe_o(io_oe_o),
    .adc_val_i(adc_val_i), .centre_online_i(centre_online_i),
    .rx_data_i(rx_data), .rx_valid_i(rx_valid), .rx_ready_o(rx_ready),
    .tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
    .link_active_o(link_active_o), .config_state_o(config_state_o));
  scio_host host (
    .clock_i(clock_i), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready),
    .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready));

  // 20 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  // Helpers: compare, bus cycles, reply wait
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock_i);
    bus_i <= '0;
    @(posedge clock_i);
  endtask
  task automatic rchk(input string w, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clock_i);
    bus_i <= '0;
    #1;
    d = rd_data_o;
    chk(w, e, d);
    @(posedge clock_i);
  endtask
  task automatic txchk(input string w, input logic [7:0] e);
    int n;
    n = 0;
    while (host.got.size() == 0 && n < 200) begin
      @(posedge clock_i);
      n++;
    end
    if (host.got.size() == 0) chk(w, {24'h0, e}, 32'hX);
    else chk(w, {24'h0, e}, {24'h0, host.got.pop_front()});
  endtask

  // Closing verdict, shared with the watchdog
  task automatic tally_and_finish;
    n_fail += host.err;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Reset state, key byte entry and code and mode setup
  task automatic t_setup;
    chk("rx_ready", 1, rx_ready);
    chk("config", 0, config_state_o);
    rchk("interval", scio_pkg::A_IVAL, 32'h1388);
    rchk("unmapped", 8'h60, 0);
    host.send(8'h41);
    cyc(15);
    chk("no key", 0, config_state_o);
    for (int i = 0; i < 8 && !config_state_o; i++) begin
      host.send(scio_pkg::CFG_KEY);
      cyc(15);
    end
    rchk("ctrl cfg", scio_pkg::A_CTRL, 1);
    for (int i = 0; i < 5; i++) begin
      wr(8'h20 + 8'(4 * i), {8'h40 + 8'(i), 8'h30 + 8'(i), 8'h20 + 8'(i), 8'h10 + 8'(i)});
    end
    wr(scio_pkg::A_MODE, 32'h6CD1);
    rchk("mode", scio_pkg::A_MODE, 32'h6CD1);
    wr(scio_pkg::A_MODE, 32'h62D6);
    rchk("mode refused", scio_pkg::A_MODE, 32'h6CD1);
    $display("test setup done");
  endtask

  // Output line driven by high and low strings
  task automatic t_output;
    host.send(8'h21);
    txchk("resp high", 8'h41);
    chk("out high", 1, io_out_o[1]);
    chk("oe out", 1, io_oe_o[1]);
    host.send(8'h31);
    txchk("resp low", 8'h41);
    chk("out low", 0, io_out_o[1]);
    $display("test output done");
  endtask

  // Query, change and timed reports of input line 1
  task automatic t_input;
    int n;
    io_pin_i[0] <= 1'b1;
    cyc(4);
    host.send(8'h10);
    txchk("query high", 8'h20);
    rchk("value 1", 8'h40, 1);
    io_pin_i[0] <= 1'b0;
    cyc(4);
    host.send(8'h10);
    txchk("query low", 8'h30);
    rchk("value 0", 8'h40, 0);
    wr(scio_pkg::A_RTYPE, 32'h2);
    io_pin_i[0] <= 1'b1;
    cyc(40);
    chk("change count", 1, 32'(host.got.size()));
    txchk("change high", 8'h20);
    io_pin_i[0] <= 1'b0;
    txchk("change low", 8'h30);
    host.slow = 1'b1;
    wr(scio_pkg::A_IVAL, 32'h5);
    wr(scio_pkg::A_RTYPE, 32'h1);
    host.got.delete();
    cyc(200);
    n = host.got.size();
    chk("timed count", 1, 32'(n >= 9 && n <= 11));
    txchk("timed low", 8'h30);
    wr(scio_pkg::A_RTYPE, 32'h0);
    host.slow = 1'b0;
    cyc(30);
    host.got.delete();
    $display("test input done");
  endtask

  // Indication, wake control and sampled values
  task automatic t_misc;
    wr(scio_pkg::A_MAP, 32'hC0);
    centre_online_i <= 5'h1B;
    cyc(4);
    chk("ind offline", 0, io_out_o[2]);
    chk("ind oe", 1, io_oe_o[2]);
    centre_online_i <= 5'h04;
    cyc(4);
    chk("ind online", 1, io_out_o[2]);
    wr(scio_pkg::A_MODE, 32'h6CD4);
    io_pin_i[0] <= 1'b1;
    cyc(5);
    chk("wake unselected", 0, link_active_o);
    wr(scio_pkg::A_CTRL, 32'h3);
    cyc(3);
    chk("wake high", 1, link_active_o);
    io_pin_i[0] <= 1'b0;
    cyc(5);
    chk("sleep low", 0, link_active_o);
    rchk("adc line4", 8'h4C, 32'hABC);
    rchk("adc line5", 8'h50, 32'h123);
    // Other pins and new samples, so no input stays fixed for the whole run
    io_pin_i  <= 5'h1E;
    adc_val_i <= {12'hFFF, 12'h000};
    cyc(4);
    rchk("status", scio_pkg::A_STAT, 32'h81E);
    rchk("adc zero", 8'h4C, 32'h000);
    rchk("adc full", 8'h50, 32'hFFF);
    $display("test misc done");
  endtask

  // Main sequence
  initial begin
    resetn_i        = 1'b0;
    bus_i           = '0;
    io_pin_i        = 5'h00;
    adc_val_i       = {12'h123, 12'hABC};
    centre_online_i = 5'h00;
    cyc(16);
    resetn_i <= 1'b1;
    cyc(4);
    t_setup;
    t_output;
    t_input;
    t_misc;
    tally_and_finish;
  end

  // Watchdog well beyond the expected run
  initial begin
    cyc(20000);
    n_fail++;
    tally_and_finish;
  end
endmodule
